// ==== design/sdhtc_pkg.sv ====
// package: register map, field layout, timing, types and crc helpers of the transfer control block
package sdhtc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_CMD = 12'h00C;
    localparam logic [11:0] OFS_ARG = 12'h010;
    localparam logic [11:0] OFS_BSZ = 12'h02C;
    localparam logic [11:0] OFS_BNUM = 12'h030;
    // control field positions
    localparam int CTL_CONT = 12;
    localparam int CTL_BURST_LSB = 8;
    localparam int CTL_GO = 7;
    localparam int CTL_LBE = 6;
    localparam int CTL_RCD = 5;
    localparam int CTL_MODE_LSB = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000000F;
    localparam logic [31:0] CTRL_WMASK = 32'h00001F7F;
    // status bit positions
    localparam int STB_CRC7 = 0;
    localparam int STB_RCRC = 1;
    localparam int STB_WCRC = 2;
    localparam int STB_CMDC = 3;
    localparam int STB_NORESP = 4;
    localparam int STB_ACKERR = 5;
    localparam int STB_TOUT = 6;
    // transfer modes
    localparam logic [3:0] MODE_CMD_ONLY = 4'h0;
    localparam logic [3:0] MODE_R6 = 4'h1;
    localparam logic [3:0] MODE_R17 = 4'h2;
    localparam logic [3:0] MODE_R6_BUSY = 4'h3;
    localparam logic [3:0] MODE_RD_CMD = 4'h4;
    localparam logic [3:0] MODE_WR_CMD = 4'h5;
    localparam logic [3:0] MODE_RD = 4'h6;
    localparam logic [3:0] MODE_WR = 4'h7;
    localparam logic [3:0] MODE_CLK = 4'h8;
    localparam logic [3:0] MODE_BOOT = 4'h9;
    localparam logic [3:0] MODE_BOOT_ACK = 4'hA;
    // timing
    localparam int CLK_NS = 5;
    localparam int CARD_CLK_NS = 50;
    localparam logic [7:0] CARD_HALF_CYC = 8'(CARD_CLK_NS / (2 * CLK_NS));
    localparam logic [15:0] RESP_WAIT = 16'h0040;
    localparam logic [15:0] DATA_WAIT = 16'h1000;
    localparam logic [15:0] BURST_UNIT_SH = 16'h0004;
    localparam logic [15:0] BURST_ZERO = 16'h0100;
    localparam logic [15:0] EXTRA_TICKS = 16'h0008;
    localparam logic [15:0] CMD_BITS = 16'h0030;
    localparam logic [15:0] LONG_BITS = 16'h0088;
    localparam logic [15:0] CRC16_BITS = 16'h0010;
    localparam logic [15:0] NWR_TICKS = 16'h0002;
    localparam logic [15:0] BUSY_MIN = 16'h0002;
    localparam logic [2:0] CRC_STAT_OK = 3'h2;
    localparam logic [3:0] ACK_PATTERN = 4'h5;

    typedef enum logic [10:0] {
        S_IDLE = 11'h001,
        S_CMD = 11'h002,
        S_RESP = 11'h004,
        S_BUSY = 11'h008,
        S_DRX = 11'h010,
        S_DTX = 11'h020,
        S_CRCS = 11'h040,
        S_ACK = 11'h080,
        S_CLKS = 11'h100,
        S_EXTRA = 11'h200,
        S_DONE = 11'h400
    } sdhtc_state_t;

    typedef struct packed {
        logic clk;
        logic cmd;
        logic cmd_oe_n;
        logic dat0;
        logic dat0_oe_n;
    } sdhtc_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sdhtc_byte_t;

    function automatic logic [6:0] sdhtc_crc7(input logic [39:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    function automatic logic [15:0] sdhtc_crc16(input logic [15:0] c, input logic b);
        logic fb;
        fb = b ^ c[15];
        return {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    endfunction
endpackage

// ==== design/sdhtc_top.sv ====
// transfer sequencer of the card host: apb registers, card clock, command and data engines
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sdhtc_top import sdhtc_pkg::*; #(
    parameter logic [7:0] CARD_HALF = CARD_HALF_CYC,
    parameter logic [15:0] DATA_WAIT_TICKS = DATA_WAIT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // card pins
    input wire logic card_cmd_i,
    input wire logic card_dat0_i,
    output sdhtc_pins_t card_o,
    // data streams
    output sdhtc_byte_t rx_o,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    sdhtc_state_t state_q, state_d;
    logic [31:0] ctrl_q, arg_q;
    logic [5:0] cmd_idx_q;
    logic [9:0] bsz_q;
    logic [15:0] bnum_q, blk_q, blk_d, cnt_q, cnt_d, wait_q, wait_d;
    logic [6:0] stat_q, set_d;
    logic go_q, bad_q, bad_d;
    logic [3:0] mode_q, burst_q;
    logic [135:0] sh_q, sh_d;
    logic [7:0] byte_q, byte_d, rxd_q, rxd_d, div_q;
    logic [15:0] crc_q, crc_d;
    logic clk_q, cmd_q, cmd_d, cmd_oen_q, cmd_oen_d, dat_q, dat_d, dat_oen_q, dat_oen_d;
    logic rxv_q, rxv_d, txr;
    logic cmd_m_q, cmd_s_q, dat_m_q, dat_s_q;

    // apb decode
    wire apb_acc = psel_i & penable_i;
    wire hit_ctrl = paddr_i == OFS_CTRL;
    wire hit_stat = paddr_i == OFS_STAT;
    wire hit_cmd = paddr_i == OFS_CMD;
    wire hit_arg = paddr_i == OFS_ARG;
    wire hit_bsz = paddr_i == OFS_BSZ;
    wire hit_bnum = paddr_i == OFS_BNUM;
    wire addr_ok = hit_ctrl | hit_stat | hit_cmd | hit_arg | hit_bsz | hit_bnum;
    wire wr_ok = apb_acc & pwrite_i & addr_ok;
    wire wr_ctrl = wr_ok & hit_ctrl;
    wire engine_run = (state_q != S_IDLE) && (state_q != S_DONE);
    wire start = wr_ctrl & pwdata_i[CTL_GO] & (state_q == S_IDLE) & ~go_q;
    wire abort = wr_ctrl & ~pwdata_i[CTL_GO] & go_q & engine_run;
    wire [3:0] new_mode = pwdata_i[CTL_MODE_LSB +: 4];
    wire [31:0] ctrl_rd = {19'h0, ctrl_q[12:8], go_q, ctrl_q[6:0]};

    assign pready_o = 1'b1;
    assign pslverr_o = apb_acc & ~addr_ok;
    assign prdata_o = hit_ctrl ? ctrl_rd :
                      hit_stat ? {24'h0, engine_run, stat_q} :
                      hit_cmd ? {26'h0, cmd_idx_q} :
                      hit_arg ? arg_q :
                      hit_bsz ? {22'h0, bsz_q} :
                      hit_bnum ? {16'h0, bnum_q} : 32'h0;

    // card clock: runs during a transfer or while continuous clocking is on
    wire clk_run = engine_run | ctrl_q[CTL_CONT];
    wire div_wrap = div_q == CARD_HALF - 8'h01;
    wire tick = div_wrap & clk_q;

    // derived lengths
    wire [15:0] nbits = {3'h0, bsz_q, 3'h0};
    wire [15:0] burst_total = (burst_q == 4'h0) ? BURST_ZERO :
                              ({12'h0, burst_q} << BURST_UNIT_SH);
    wire [15:0] resp_len = (mode_q == MODE_R17) ? LONG_BITS : CMD_BITS;
    wire [135:0] resp_next = {sh_q[134:0], cmd_s_q};
    wire resp_crc_bad = sdhtc_crc7(resp_next[47:8]) != resp_next[7:1];
    wire [15:0] dtx_idx = cnt_q - (NWR_TICKS + 16'h0001);
    wire [39:0] cmd_head = {2'b01, cmd_idx_q, arg_q};
    wire [47:0] cmd_frame = {cmd_head, sdhtc_crc7(cmd_head), 1'b1};
    wire last_blk = blk_q <= 16'h0001;

    // first state after go, per mode
    sdhtc_state_t first_st, after_cmd, after_resp;
    always_comb begin
        unique case (new_mode)
            MODE_CMD_ONLY, MODE_R6, MODE_R17, MODE_R6_BUSY, MODE_RD_CMD, MODE_WR_CMD,
            MODE_BOOT, MODE_BOOT_ACK: first_st = S_CMD;
            MODE_RD: first_st = S_DRX;
            MODE_WR: first_st = S_DTX;
            MODE_CLK: first_st = S_CLKS;
            default: first_st = S_DONE;
        endcase
    end
    always_comb begin
        unique case (mode_q)
            MODE_CMD_ONLY: after_cmd = S_DONE;
            MODE_BOOT, MODE_BOOT_ACK: after_cmd = S_ACK;
            default: after_cmd = S_RESP;
        endcase
    end
    always_comb begin
        unique case (mode_q)
            MODE_R6_BUSY: after_resp = S_BUSY;
            MODE_RD_CMD: after_resp = S_DRX;
            MODE_WR_CMD: after_resp = S_DTX;
            default: after_resp = S_DONE;
        endcase
    end

    // sequencer next state; every bit step happens on a falling card clock edge
    always_comb begin
        logic txbit;
        txbit = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        wait_d = wait_q;
        sh_d = sh_q;
        byte_d = byte_q;
        crc_d = crc_q;
        bad_d = bad_q;
        blk_d = blk_q;
        cmd_d = cmd_q;
        cmd_oen_d = cmd_oen_q;
        dat_d = dat_q;
        dat_oen_d = dat_oen_q;
        rxd_d = rxd_q;
        rxv_d = 1'b0;
        set_d = 7'h00;
        txr = 1'b0;
        if (start) begin
            state_d = first_st;
            cnt_d = 16'h0;
            wait_d = 16'h0;
            blk_d = bnum_q;
            sh_d = {88'h0, cmd_frame};
        end else if (abort) begin
            state_d = S_DONE;
            cmd_oen_d = 1'b1;
            dat_oen_d = 1'b1;
        end else if (state_q == S_DONE) begin
            state_d = S_IDLE;
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001;
            cmd_d = 1'b1;
            cmd_oen_d = 1'b1;
            dat_d = 1'b1;
            dat_oen_d = 1'b1;
            unique case (state_q)
                S_IDLE: ;
                S_DONE: ;
                S_CMD: begin
                    // one extra tick so the end bit gets its rising card clock before release
                    if (cnt_q == CMD_BITS) begin
                        cnt_d = 16'h0;
                        state_d = after_cmd;
                        set_d[STB_CMDC] = mode_q == MODE_CMD_ONLY;
                    end else begin
                        cmd_oen_d = 1'b0;
                        cmd_d = sh_q[47];
                        sh_d = {sh_q[134:0], 1'b0};
                    end
                end
                S_RESP: begin
                    sh_d = resp_next;
                    if (cnt_q == 16'h0 && cmd_s_q) begin
                        cnt_d = 16'h0;
                        wait_d = wait_q + 16'h0001;
                        if (wait_q == RESP_WAIT - 16'h0001) begin
                            set_d[STB_NORESP] = 1'b1;
                            state_d = S_DONE;
                        end
                    end else if (cnt_q == resp_len - 16'h0001) begin
                        cnt_d = 16'h0;
                        wait_d = 16'h0;
                        set_d[STB_CMDC] = 1'b1;
                        if (resp_len == CMD_BITS && !ctrl_q[CTL_RCD] && resp_crc_bad) begin
                            set_d[STB_CRC7] = 1'b1;
                            state_d = S_DONE;
                        end else begin
                            state_d = after_resp;
                        end
                    end
                end
                S_BUSY: begin
                    if (cnt_q >= BUSY_MIN && dat_s_q) begin
                        cnt_d = 16'h0;
                        wait_d = 16'h0;
                        if (mode_q == MODE_R6_BUSY || last_blk) begin
                            state_d = S_DONE;
                        end else begin
                            blk_d = blk_q - 16'h0001;
                            state_d = S_DTX;
                        end
                    end else begin
                        wait_d = wait_q + 16'h0001;
                        if (wait_q == DATA_WAIT_TICKS - 16'h0001) begin
                            set_d[STB_TOUT] = 1'b1;
                            state_d = S_DONE;
                        end
                    end
                end
                S_DRX: begin
                    if (cnt_q == 16'h0) begin
                        crc_d = 16'h0;
                        bad_d = 1'b0;
                        if (dat_s_q) begin
                            cnt_d = 16'h0;
                            wait_d = wait_q + 16'h0001;
                            if (wait_q == DATA_WAIT_TICKS - 16'h0001) begin
                                set_d[STB_TOUT] = 1'b1;
                                state_d = S_DONE;
                            end
                        end
                    end else if (cnt_q <= nbits) begin
                        byte_d = {byte_q[6:0], dat_s_q};
                        crc_d = sdhtc_crc16(crc_q, dat_s_q);
                        if (cnt_q[2:0] == 3'h0) begin
                            rxd_d = {byte_q[6:0], dat_s_q};
                            rxv_d = 1'b1;
                        end
                    end else if (cnt_q <= nbits + CRC16_BITS) begin
                        bad_d = bad_q | (dat_s_q ^ crc_q[15]);
                        crc_d = {crc_q[14:0], 1'b0};
                    end else begin
                        cnt_d = 16'h0;
                        wait_d = 16'h0;
                        if (bad_q) begin
                            set_d[STB_RCRC] = 1'b1;
                            state_d = S_DONE;
                        end else if (last_blk) begin
                            state_d = ctrl_q[CTL_LBE] ? S_EXTRA : S_DONE;
                        end else begin
                            blk_d = blk_q - 16'h0001;
                        end
                    end
                end
                S_DTX: begin
                    dat_oen_d = 1'b0;
                    if (cnt_q == NWR_TICKS) begin
                        dat_d = 1'b0;
                        crc_d = 16'h0;
                    end else if (cnt_q > NWR_TICKS && cnt_q <= nbits + NWR_TICKS) begin
                        if (dtx_idx[2:0] == 3'h0) begin
                            txbit = tx_data_i[7];
                            byte_d = {tx_data_i[6:0], 1'b0};
                            txr = 1'b1;
                        end else begin
                            txbit = byte_q[7];
                            byte_d = {byte_q[6:0], 1'b0};
                        end
                        dat_d = txbit;
                        crc_d = sdhtc_crc16(crc_q, txbit);
                    end else if (cnt_q > NWR_TICKS && cnt_q <= nbits + NWR_TICKS + CRC16_BITS) begin
                        dat_d = crc_q[15];
                        crc_d = {crc_q[14:0], 1'b0};
                    end else if (cnt_q > NWR_TICKS) begin
                        cnt_d = 16'h0;
                        wait_d = 16'h0;
                        state_d = S_CRCS;
                    end
                end
                S_CRCS, S_ACK: begin
                    if (cnt_q == 16'h0 && dat_s_q) begin
                        cnt_d = 16'h0;
                        wait_d = wait_q + 16'h0001;
                        if (wait_q == DATA_WAIT_TICKS - 16'h0001) begin
                            set_d[STB_TOUT] = 1'b1;
                            state_d = S_DONE;
                        end
                    end else if (cnt_q != 16'h0) begin
                        byte_d = {byte_q[6:0], dat_s_q};
                        if (state_q == S_CRCS && cnt_q == 16'h0003) begin
                            cnt_d = 16'h0;
                            wait_d = 16'h0;
                            if ({byte_q[1:0], dat_s_q} != CRC_STAT_OK) begin
                                set_d[STB_WCRC] = 1'b1;
                                state_d = S_DONE;
                            end else begin
                                state_d = S_BUSY;
                            end
                        end else if (state_q == S_ACK && cnt_q == 16'h0004) begin
                            cnt_d = 16'h0;
                            wait_d = 16'h0;
                            if (mode_q == MODE_BOOT_ACK && {byte_q[2:0], dat_s_q} != ACK_PATTERN) begin
                                set_d[STB_ACKERR] = 1'b1;
                                state_d = S_DONE;
                            end else begin
                                state_d = S_DRX;
                            end
                        end
                    end
                end
                S_CLKS: begin
                    if (cnt_q == burst_total - 16'h0001) state_d = S_DONE;
                end
                S_EXTRA: begin
                    if (cnt_q == EXTRA_TICKS - 16'h0001) state_d = S_DONE;
                end
            endcase
        end
    end

    assign tx_ready_o = txr;
    assign rx_o = '{valid: rxv_q, data: rxd_q};
    assign card_o = '{clk: clk_q, cmd: cmd_q, cmd_oe_n: cmd_oen_q, dat0: dat_q,
                      dat0_oe_n: dat_oen_q};

    // registers written by software
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= CTRL_RST;
            arg_q <= 32'h0;
            cmd_idx_q <= 6'h00;
            bsz_q <= 10'h000;
            bnum_q <= 16'h0;
        end else if (wr_ok) begin
            if (hit_ctrl) ctrl_q <= pwdata_i & CTRL_WMASK;
            if (hit_arg) arg_q <= pwdata_i;
            if (hit_cmd) cmd_idx_q <= pwdata_i[5:0];
            if (hit_bsz) bsz_q <= pwdata_i[9:0];
            if (hit_bnum) bnum_q <= pwdata_i[15:0];
        end
    end

    // go bit, latched mode, status flags
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            go_q <= 1'b0;
            mode_q <= CTRL_RST[3:0];
            burst_q <= 4'h0;
            stat_q <= 7'h00;
        end else begin
            go_q <= start | (go_q & (state_q != S_DONE));
            if (start) begin
                mode_q <= new_mode;
                burst_q <= pwdata_i[CTL_BURST_LSB +: 4];
            end
            stat_q <= start ? 7'h00 : (stat_q | set_d);
        end
    end

    // card clock divider and input synchronisers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= 8'h00;
            clk_q <= 1'b0;
            cmd_m_q <= 1'b1;
            cmd_s_q <= 1'b1;
            dat_m_q <= 1'b1;
            dat_s_q <= 1'b1;
        end else begin
            div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
            if (div_wrap) clk_q <= ~clk_q & clk_run;
            cmd_m_q <= card_cmd_i;
            cmd_s_q <= cmd_m_q;
            dat_m_q <= card_dat0_i;
            dat_s_q <= dat_m_q;
        end
    end

    // sequencer registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            cnt_q <= 16'h0;
            wait_q <= 16'h0;
            sh_q <= 136'h0;
            byte_q <= 8'h00;
            crc_q <= 16'h0;
            bad_q <= 1'b0;
            blk_q <= 16'h0;
            cmd_q <= 1'b1;
            cmd_oen_q <= 1'b1;
            dat_q <= 1'b1;
            dat_oen_q <= 1'b1;
            rxd_q <= 8'h00;
            rxv_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wait_q <= wait_d;
            sh_q <= sh_d;
            byte_q <= byte_d;
            crc_q <= crc_d;
            bad_q <= bad_d;
            blk_q <= blk_d;
            cmd_q <= cmd_d;
            cmd_oen_q <= cmd_oen_d;
            dat_q <= dat_d;
            dat_oen_q <= dat_oen_d;
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
        end
    end
endmodule

// ==== tb/sdhtc_card.sv ====
// card model: released lines go to the pull-up level unless the card holds them low
`timescale 1ns/1ps
module sdhtc_card import sdhtc_pkg::*; (
    // host pins in, resolved line levels out
    input sdhtc_pins_t card_i,
    input wire logic hold_i,
    output logic cmd_o,
    output logic dat0_o
);
    // holding both lines low gives an all-zero response, ack and block with zero crc
    assign cmd_o = card_i.cmd_oe_n ? !hold_i : card_i.cmd;
    assign dat0_o = card_i.dat0_oe_n ? !hold_i : card_i.dat0;
endmodule

// ==== tb/sdhtc_checker.sv ====
// port assertions for the transfer control block
`timescale 1ns/1ps
module sdhtc_checker import sdhtc_pkg::*; (
    // apb and card pins of the block
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input sdhtc_pins_t card_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic cont_q;
    wire logic [11:0] a = paddr_i;
    wire logic [3:0] md = pwdata_i[3:0];
    wire logic acc = psel_i && penable_i;
    wire logic ctl = acc && pwrite_i && a == OFS_CTRL;
    wire logic go = ctl && pwdata_i[CTL_GO];
    wire logic rsv = go && md > MODE_BOOT_ACK && !pwdata_i[CTL_CONT] && !cont_q;
    wire logic unmap = !(a inside {OFS_CTRL, OFS_STAT, OFS_CMD, OFS_ARG, OFS_BSZ, OFS_BNUM});
    // mirror of the continuous clock bit
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) cont_q <= 1'b0;
        else if (ctl) cont_q <= pwdata_i[CTL_CONT];
    end
    pready_a: assert property (acc |-> pready_o)
        else $error("pready low in access phase");
    unmapped_a: assert property (acc && unmap |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    ctrl_bits_a: assert property (acc && !pwrite_i && a == OFS_CTRL |->
        (prdata_o & ~(CTRL_WMASK | 32'h80)) == 32'h0) else $error("stray control bits");
    cont_run_a: assert property (cont_q |-> ##[0:12] $changed(card_o.clk))
        else $error("card clock idle while continuous");
    cont_half_a: assert property ($rose(card_o.clk) && cont_q |=> card_o.clk [*4])
        else $error("card clock high phase short");
    burst_go_a: assert property (go && md == MODE_CLK |-> ##[1:20] $changed(card_o.clk))
        else $error("clock burst did not start");
    rsv_idle_a: assert property (rsv |=> (card_o.cmd_oe_n && !card_o.clk) [*8])
        else $error("reserved mode moved the pins");
    cmd_go_a: assert property (go && md == MODE_CMD_ONLY |-> ##[1:40] !card_o.cmd_oe_n)
        else $error("command line not driven");
endmodule
bind sdhtc_top sdhtc_checker sdhtc_checker_i (.*);

// ==== tb/tb_top.sv ====
// self-checking bench for the transfer control block
`timescale 1ns/1ps
module tb_top import sdhtc_pkg::*;;
    logic clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [7:0] tx_data_i = 8'hA5, rx_or = 8'h00;
    logic hold = 1'b0;
    logic pready_o, pslverr_o, card_cmd_i, card_dat0_i, tx_ready_o, clk_prev = 1'b0;
    logic [47:0] cmd_sr = 48'h0;
    sdhtc_pins_t card_o;
    sdhtc_byte_t rx_o;
    int edges = 0, fail_count = 0, n_compared = 0, rx_n = 0, tx_n = 0;
    initial forever #2.5 clk_i = ~clk_i;
    sdhtc_top #(.DATA_WAIT_TICKS(16'h0040)) sdhtc_top_i (.*);
    sdhtc_card sdhtc_card_i (.card_i(card_o), .hold_i(hold), .cmd_o(card_cmd_i),
                             .dat0_o(card_dat0_i));
    // count card clock rises, shifting in driven command bits
    always @(posedge clk_i) begin
        clk_prev <= card_o.clk;
        if (rx_o.valid) rx_n <= rx_n + 1;
        if (rx_o.valid) rx_or <= rx_or | rx_o.data;
        if (tx_ready_o) tx_n <= tx_n + 1;
        if (card_o.clk && !clk_prev) begin
            edges <= edges + 1;
            if (!card_o.cmd_oe_n) cmd_sr <= {cmd_sr[46:0], card_o.cmd};
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang(input string nm);
        fail_count++;
        $display("Error %s expected done seen timeout", nm);
        stop_test();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) hang("pready");
    endtask
    task automatic wait_go(input int lim);
        int n = 0;
        do apb(1'b0, OFS_CTRL, 32'h0); while (rd[CTL_GO] !== 1'b0 && ++n < lim);
        if (rd[CTL_GO] !== 1'b0) hang("go clear");
    endtask
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, CTRL_RST);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped read", rd, 32'h0);
        $display("register test done");
    endtask
    task automatic t_cmd();
        apb(1'b1, OFS_CMD, 32'h11);
        apb(1'b1, OFS_CTRL, 32'h80);
        wait_go(400);
        chk("command head", cmd_sr[47:40], 8'h51);
        chk("command end", cmd_sr[0], 1'b1);
        apb(1'b1, OFS_CTRL, 32'h81);
        wait_go(1000);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("no response", rd[STB_NORESP], 1'b1);
        $display("command test done");
    endtask
    task automatic t_burst();
        int base;
        for (int b = 0; b < 2; b++) begin
            base = edges;
            apb(1'b1, OFS_CTRL, 32'h88 | (b << 8));
            apb(1'b0, OFS_STAT, 32'h0);
            chk("flags cleared", rd[6:0], 7'h0);
            wait_go(1200);
            chk("burst clocks", edges - base, b ? 16 : 256);
        end
        $display("burst test done");
    endtask
    task automatic t_data();
        int e, r;
        apb(1'b1, OFS_BSZ, 32'h1);
        hold <= 1'b1;
        e = edges;
        r = rx_n;
        apb(1'b1, OFS_CTRL, 32'hC6);
        wait_go(200);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("read clocks", edges - e, 34);
        chk("read bytes", rx_n - r, 1);
        chk("read flags", rd[6:0], 7'h0);
        r = tx_n;
        apb(1'b1, OFS_CTRL, 32'h87);
        wait_go(200);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("write bytes", tx_n - r, 1);
        chk("crc status", rd[STB_WCRC], 1'b1);
        apb(1'b1, OFS_CTRL, 32'h83);
        wait_go(700);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("response crc", rd[STB_CRC7], 1'b0);
        chk("busy timeout", rd[STB_TOUT], 1'b1);
        r = rx_n;
        apb(1'b1, OFS_CTRL, 32'h89);
        wait_go(400);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("boot bytes", rx_n - r, 1);
        chk("boot flags", rd[6:0], 7'h0);
        apb(1'b1, OFS_CTRL, 32'h8A);
        wait_go(400);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("boot ack", rd[STB_ACKERR], 1'b1);
        chk("read data", rx_or, 8'h00);
        hold <= 1'b0;
        $display("data test done");
    endtask
    task automatic t_abort();
        int base;
        for (int m = 1; m < 11; m++) begin
            if (m == 8) continue;
            apb(1'b1, OFS_CTRL, 32'h80 | m);
            apb(1'b1, OFS_CTRL, m);
            wait_go(3);
            base = edges;
            repeat (50) @(posedge clk_i);
            chk("clocks after abort", edges - base, 0);
            chk("lines released", {card_o.cmd_oe_n, card_o.dat0_oe_n}, 2'b11);
        end
        $display("abort test done");
    endtask
    task automatic t_cont();
        int base;
        base = edges;
        apb(1'b1, OFS_CTRL, 32'h100F);
        repeat (100) @(posedge clk_i);
        chk("continuous clocks", edges - base >= 8, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h1188);
        apb(1'b1, OFS_CTRL, 32'h0188);
        wait_go(100);
        repeat (20) @(posedge clk_i);
        base = edges;
        for (int m = 11; m < 16; m++) begin
            apb(1'b1, OFS_CTRL, 32'h80 | m);
            wait_go(4);
        end
        chk("clock stopped", edges - base, 0);
        $display("continuous test done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_cmd();
        t_burst();
        t_data();
        t_abort();
        t_cont();
        stop_test();
    end
endmodule
